// File: verilog/fapg_guard.sv
/*
  Flash and SRAM access permission guard with an APB register slave.
  Assumes one 25 MHz clock, requests synchronous to it, and a memory array
  behind acc_grant that performs only granted operations.
*/
`timescale 1ns/1ps
`include "fapg_params.svh"
module fapg_guard (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic acc_debug,
  input wire logic [1:0] acc_op,
  input wire logic [1:0] acc_size,
  input wire logic [31:0] acc_addr,
  output logic acc_grant,
  output logic acc_deny,
  output logic acc_sram_sel,
  output logic acc_boot_keep,
  output logic erase_all_req,
  input wire logic erase_all_done,
  input wire logic power_down_state,
  output logic sram_invalid
);
  fapg_pkg::fapg_level_t level;
  fapg_pkg::fapg_state_t state;
  logic [31:0] option_shadow_word;
  logic [31:0] opt_user;
  logic [1:0] wait_state_count;
  logic prefetch_buffer_on;
  logic prefetch_buffer_state;
  logic flash_unlocked;
  logic key_half;
  logic opt_unlocked;
  logic opt_key_half;
  logic keys_dead;
  logic write_guard_fault_flag;
  logic operation_done_flag;
  logic boot_lock;
  logic [7:0] pend_one;
  logic [7:0] pend_one_c;
  logic [7:0] level_one_guard_byte;
  logic [7:0] level_one_guard_complement;
  logic [7:0] level_two_guard_byte;
  logic [7:0] level_two_guard_complement;
  logic apb_go;
  logic apb_wr;
  logic next_grant;
  logic in_boot;
  logic in_main;
  logic in_opt;
  logic in_sys;
  logic in_sram;
  logic is_read;
  logic next_deny;
  logic lvl_ok;
  logic [7:0] new_two;
  logic [7:0] new_two_c;
  logic [7:0] new_one;
  logic [7:0] new_one_c;
  logic to_zero;
  logic to_two;
  logic pfault;

  // ******************************************************************
  // Protection level decode
  // ******************************************************************
  fapg_level_decode u_dec (
    .level_one_guard_byte(level_one_guard_byte),
    .level_one_guard_complement(level_one_guard_complement),
    .level_two_guard_byte(level_two_guard_byte),
    .level_two_guard_complement(level_two_guard_complement),
    .level(level)
  );
  assign level_one_guard_byte = option_shadow_word[7:0];
  assign level_one_guard_complement = option_shadow_word[15:8];
  assign level_two_guard_byte = option_shadow_word[23:16];
  assign level_two_guard_complement = option_shadow_word[31:24];
  assign boot_lock = opt_user[3];

  // ******************************************************************
  // APB decode
  // ******************************************************************
  // Every register answers in the access cycle; no wait states needed.
  assign apb_go = psel && penable && clk_en;
  assign apb_wr = apb_go && pwrite;
  assign new_one = pwdata[7:0];
  assign new_one_c = pwdata[15:8];
  assign new_two = pwdata[23:16];
  assign new_two_c = pwdata[31:24];
  assign to_two = (new_two == `FAPG_TWO_GUARD) && (new_two_c == `FAPG_TWO_COMPL);
  assign to_zero = !to_two && (new_one == `FAPG_ONE_GUARD) && (new_one_c == `FAPG_ONE_COMPL);
  // Level two is final; zero and one may go anywhere else.
  assign lvl_ok = (level != fapg_pkg::FAPG_LVL_TWO) && opt_unlocked;
  // Level word writes are refused and flagged unless the option key is unlocked, or once level two is set.
  assign pfault = apb_wr && (paddr == `FAPG_OFF_LVL) && !lvl_ok;

  // ******************************************************************
  // Key unlock sequences
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_unlocked <= 1'b0;
      key_half <= 1'b0;
      opt_unlocked <= 1'b0;
      opt_key_half <= 1'b0;
      keys_dead <= 1'b0;
    end else if (apb_wr && !keys_dead) begin
      if (paddr == `FAPG_OFF_KEY) begin
        if (!key_half && pwdata == `FAPG_KEY1) begin
          key_half <= 1'b1;
        end else if (key_half && pwdata == `FAPG_KEY2) begin
          flash_unlocked <= 1'b1;
          key_half <= 1'b0;
        end else begin
          keys_dead <= 1'b1;
        end
      end else if (paddr == `FAPG_OFF_OPT_KEY) begin
        if (flash_unlocked && !opt_key_half && pwdata == `FAPG_KEY1) begin
          opt_key_half <= 1'b1;
        end else if (opt_key_half && pwdata == `FAPG_KEY2) begin
          opt_unlocked <= 1'b1;
          opt_key_half <= 1'b0;
        end else begin
          keys_dead <= 1'b1;
          opt_unlocked <= 1'b0;
        end
      end
    end
  end

  // ******************************************************************
  // Control and option registers
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_state_count <= 2'h0;
      prefetch_buffer_on <= 1'b1;
      prefetch_buffer_state <= 1'b1;
      opt_user <= 32'h000000ff;
    end else if (clk_en) begin
      prefetch_buffer_state <= prefetch_buffer_on;
      if (apb_wr && paddr == `FAPG_OFF_AC) begin
        wait_state_count <= pwdata[`FAPG_AC_LAT_LSB +: 2];
        prefetch_buffer_on <= pwdata[`FAPG_AC_PFE_BIT];
      end
      if (apb_wr && paddr == `FAPG_OFF_OPT && opt_unlocked) begin
        opt_user <= pwdata;
      end
    end
  end

  // Guard bytes start erased, which reads back as level one until written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_shadow_word <= {4{`FAPG_ERASED}};
      pend_one <= `FAPG_ERASED;
      pend_one_c <= `FAPG_ERASED;
      state <= fapg_pkg::FAPG_ST_IDLE;
    end else if (clk_en) begin
      unique case (state)
        fapg_pkg::FAPG_ST_IDLE: begin
          if (apb_wr && paddr == `FAPG_OFF_LVL && lvl_ok) begin
            if (to_zero && level == fapg_pkg::FAPG_LVL_ONE) begin
              // The new level waits until the whole main array is erased.
              pend_one <= new_one;
              pend_one_c <= new_one_c;
              state <= fapg_pkg::FAPG_ST_ERASE;
            end else begin
              option_shadow_word <= pwdata;
            end
          end
        end
        fapg_pkg::FAPG_ST_ERASE: begin
          if (erase_all_done) begin
            option_shadow_word <= {16'hffff, pend_one_c, pend_one};
            state <= fapg_pkg::FAPG_ST_DONE;
          end
        end
        fapg_pkg::FAPG_ST_DONE: begin
          state <= fapg_pkg::FAPG_ST_IDLE;
        end
      endcase
    end
  end

  // ******************************************************************
  // Access permission check
  // ******************************************************************
  assign in_main = acc_addr < `FAPG_FLASH_SIZE;
  assign in_boot = acc_addr < `FAPG_BOOT_BYTES;
  assign in_opt = acc_addr >= `FAPG_OPT_BASE && acc_addr <= `FAPG_OPT_END;
  assign in_sys = acc_addr >= `FAPG_SYS_BASE && acc_addr <= `FAPG_SYS_END;
  assign in_sram = acc_addr >= `FAPG_SRAM_BASE && acc_addr <= `FAPG_SRAM_LAST;
  assign is_read = acc_op == fapg_pkg::FAPG_OP_READ;

  always_comb begin
    next_grant = 1'b0;
    if (acc_op == fapg_pkg::FAPG_OP_MASS_ERASE) begin
      // Mass erase is allowed except from debug above level zero; the lock only narrows what it clears.
      next_grant = !(acc_debug && level != fapg_pkg::FAPG_LVL_ZERO);
    end else if (in_sram) begin
      // Byte, half-word and word sizes all pass; size 3 is not a size.
      next_grant = (acc_size != 2'h3) && (acc_op != fapg_pkg::FAPG_OP_PAGE_ERASE) &&
                   !(acc_debug && level != fapg_pkg::FAPG_LVL_ZERO);
    end else if (in_main) begin
      if (acc_debug && level != fapg_pkg::FAPG_LVL_ZERO) begin
        next_grant = 1'b0;
      end else if (is_read) begin
        next_grant = 1'b1;
      end else if (in_boot) begin
        next_grant = (level == fapg_pkg::FAPG_LVL_ZERO) && !boot_lock;
      end else begin
        next_grant = 1'b1;
      end
    end else if (in_opt) begin
      if (level == fapg_pkg::FAPG_LVL_TWO) begin
        next_grant = is_read && !acc_debug;
      end else begin
        next_grant = is_read || opt_unlocked;
      end
    end else if (in_sys) begin
      next_grant = is_read;
    end
  end
  assign next_deny = acc_valid && !next_grant;

  // Grant is one registered cycle, so SRAM fetches see no extra wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_grant <= 1'b0;
      acc_deny <= 1'b0;
      acc_sram_sel <= 1'b0;
      acc_boot_keep <= 1'b0;
    end else if (clk_en) begin
      acc_grant <= acc_valid && next_grant;
      acc_deny <= next_deny;
      acc_sram_sel <= acc_valid && in_sram;
      acc_boot_keep <= acc_valid && boot_lock &&
                       acc_op == fapg_pkg::FAPG_OP_MASS_ERASE;
    end
  end

  // ******************************************************************
  // Status, erase request, SRAM validity
  // ******************************************************************
  // Hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_guard_fault_flag <= 1'b0;
      operation_done_flag <= 1'b0;
      erase_all_req <= 1'b0;
      sram_invalid <= 1'b0;
    end else if (clk_en) begin
      if (next_deny || pfault) begin
        write_guard_fault_flag <= 1'b1;
      end else if (apb_wr && paddr == `FAPG_OFF_STS && pwdata[`FAPG_STS_WRP_BIT]) begin
        write_guard_fault_flag <= 1'b0;
      end
      if (state == fapg_pkg::FAPG_ST_DONE) begin
        operation_done_flag <= 1'b1;
      end else if (apb_wr && paddr == `FAPG_OFF_STS && pwdata[`FAPG_STS_DONE_BIT]) begin
        operation_done_flag <= 1'b0;
      end
      erase_all_req <= state == fapg_pkg::FAPG_ST_ERASE && !erase_all_done;
      // Stop keeps SRAM; only power-down marks the contents lost.
      if (power_down_state) begin
        sram_invalid <= 1'b1;
      end else if (acc_valid && in_sram && acc_op == fapg_pkg::FAPG_OP_WRITE) begin
        sram_invalid <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // APB read data and response
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        if (!pwrite) begin
          unique case (paddr)
            `FAPG_OFF_AC: prdata <= {26'h0, prefetch_buffer_state, prefetch_buffer_on,
                                     2'h0, wait_state_count};
            `FAPG_OFF_STS: prdata <= {26'h0, operation_done_flag, write_guard_fault_flag,
                                      3'h0, state == fapg_pkg::FAPG_ST_ERASE};
            `FAPG_OFF_OPT: prdata <= opt_user;
            `FAPG_OFF_LVL: prdata <= option_shadow_word;
            `FAPG_OFF_REQ: prdata <= {29'h0, level};
            default: prdata <= 32'h00000000;
          endcase
        end
        // Only aligned word offsets in the map answer without error.
        pslverr <= paddr[1:0] != 2'h0 || paddr > `FAPG_OFF_LVL;
      end
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  sequence s_lower_req;
    apb_wr && paddr == `FAPG_OFF_LVL && lvl_ok && to_zero &&
      level == fapg_pkg::FAPG_LVL_ONE && state == fapg_pkg::FAPG_ST_IDLE && clk_en;
  endsequence
  a_lower_erases: assert property (@(posedge pclk) disable iff (!presetn)
    s_lower_req |=> state == fapg_pkg::FAPG_ST_ERASE && level == fapg_pkg::FAPG_LVL_ONE)
    else $error("lowering skipped erase");
  a_level_two_final: assert property (@(posedge pclk) disable iff (!presetn)
    level == fapg_pkg::FAPG_LVL_TWO |=> level == fapg_pkg::FAPG_LVL_TWO)
    else $error("level two changed");
  a_boot_read_only: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && acc_valid && in_boot && !is_read && acc_op != fapg_pkg::FAPG_OP_MASS_ERASE &&
      (boot_lock || level != fapg_pkg::FAPG_LVL_ZERO) |=> acc_deny && !acc_grant)
    else $error("boot area written");
  a_boot_open: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && acc_valid && in_boot && !acc_debug && !boot_lock &&
      level == fapg_pkg::FAPG_LVL_ZERO |=> acc_grant)
    else $error("open boot area refused");
  a_debug_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && acc_valid && acc_debug && (in_main || in_sram) &&
      level != fapg_pkg::FAPG_LVL_ZERO |=> !acc_grant)
    else $error("debug reached memory");
  a_opt_two_ro: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && acc_valid && in_opt && level == fapg_pkg::FAPG_LVL_TWO &&
      acc_op != fapg_pkg::FAPG_OP_MASS_ERASE && (!is_read || acc_debug) |=> acc_deny)
    else $error("option area open at two");
  a_sys_read_only: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && acc_valid && in_sys && !is_read &&
      acc_op != fapg_pkg::FAPG_OP_MASS_ERASE |=> acc_deny)
    else $error("system area written");
  a_deny_flags: assert property (@(posedge pclk) disable iff (!presetn)
    acc_deny && clk_en |=> write_guard_fault_flag)
    else $error("deny without fault flag");
  a_sram_window: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && acc_valid && acc_addr == 32'h20000c00 |=> !acc_sram_sel)
    else $error("sram past window");
  a_answer_next: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && acc_valid |=> acc_grant ^ acc_deny)
    else $error("access answer late");
endmodule

// File: verilog/fapg_params.svh
/*
  Offsets, field positions, reset values and key constants of the flash and SRAM
  permission guard. Assumes inclusion by bare name from design and bench files.
*/
`ifndef FAPG_PARAMS_SVH
`define FAPG_PARAMS_SVH
`define FAPG_OFF_AC 12'h000
`define FAPG_OFF_KEY 12'h004
`define FAPG_OFF_OPT_KEY 12'h008
`define FAPG_OFF_STS 12'h00c
`define FAPG_OFF_OPT 12'h010
`define FAPG_OFF_REQ 12'h014
`define FAPG_OFF_LVL 12'h018
`define FAPG_AC_RESET 32'h00000030
`define FAPG_AC_LAT_LSB 0
`define FAPG_AC_PFE_BIT 4
`define FAPG_AC_PFS_BIT 5
`define FAPG_STS_WRP_BIT 4
`define FAPG_STS_DONE_BIT 5
`define FAPG_KEY1 32'h45670123
`define FAPG_KEY2 32'hcdef89ab
`define FAPG_ONE_GUARD 8'ha5
`define FAPG_ONE_COMPL 8'h5a
`define FAPG_TWO_GUARD 8'hcc
`define FAPG_TWO_COMPL 8'h33
`define FAPG_ERASED 8'hff
`define FAPG_BOOT_BYTES 32'h00000c00
`define FAPG_FLASH_BASE 32'h00000000
`define FAPG_FLASH_SIZE 32'h00008000
`define FAPG_OPT_BASE 32'h1fffc000
`define FAPG_OPT_END 32'h1fffc3ff
`define FAPG_SYS_BASE 32'h1fff0000
`define FAPG_SYS_END 32'h1fff3fff
`define FAPG_SRAM_BASE 32'h20000000
`define FAPG_SRAM_LAST 32'h20000bff
`endif

// File: verilog/fapg_pkg.sv
/*
  Types shared by the permission guard files. Assumes nothing outside.
*/
package fapg_pkg;
  typedef enum logic [2:0] {
    FAPG_LVL_ZERO = 3'b001,
    FAPG_LVL_ONE = 3'b010,
    FAPG_LVL_TWO = 3'b100
  } fapg_level_t;
  typedef enum logic [1:0] {
    FAPG_OP_READ = 2'h0,
    FAPG_OP_WRITE = 2'h1,
    FAPG_OP_PAGE_ERASE = 2'h2,
    FAPG_OP_MASS_ERASE = 2'h3
  } fapg_op_t;
  typedef enum logic [2:0] {
    FAPG_ST_IDLE = 3'b001,
    FAPG_ST_ERASE = 3'b010,
    FAPG_ST_DONE = 3'b100
  } fapg_state_t;
endpackage

// File: verilog/fapg_level_decode.sv
/*
  Decodes protection level from the guard bytes and their complements.
  Assumes stable option bytes held in registers by the caller.
*/
`timescale 1ns/1ps
`include "fapg_params.svh"
module fapg_level_decode (
  input wire logic [7:0] level_one_guard_byte,
  input wire logic [7:0] level_one_guard_complement,
  input wire logic [7:0] level_two_guard_byte,
  input wire logic [7:0] level_two_guard_complement,
  output fapg_pkg::fapg_level_t level
);
  logic is_two;
  logic is_zero;
  // Level two wins regardless of the level-one bytes.
  assign is_two = (level_two_guard_byte == `FAPG_TWO_GUARD) &&
                  (level_two_guard_complement == `FAPG_TWO_COMPL);
  assign is_zero = (level_one_guard_byte == `FAPG_ONE_GUARD) &&
                   (level_one_guard_complement == `FAPG_ONE_COMPL) && !is_two;
  assign level = is_two ? fapg_pkg::FAPG_LVL_TWO :
                 (is_zero ? fapg_pkg::FAPG_LVL_ZERO : fapg_pkg::FAPG_LVL_ONE);
endmodule

// File: bench/fapg_flash_model.sv
/*
  Behavioural model of the main flash array behind the permission guard.
  Assumes erase_all_req is a level held until erase_all_done pulses once.
*/
`timescale 1ns/1ps
module fapg_flash_model #(
  parameter int ERASE_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic erase_all_req,
  output logic erase_all_done
);
  int count;
  // ****************************************
  // Whole array erase
  // ****************************************
  // A real array takes milliseconds; a short fixed count keeps the run brief.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 0;
      erase_all_done <= 1'b0;
    end else begin
      erase_all_done <= 1'b0;
      if (erase_all_req && !erase_all_done) begin
        count <= count + 1;
        if (count == ERASE_CYCLES) begin
          erase_all_done <= 1'b1;
          count <= 0;
        end
      end
    end
  end
endmodule

// File: bench/fapg_guard_test.sv
/*
  Self-checking bench for the permission guard: APB master, access driver,
  queued expectations. Assumes the flash model answers mass erase requests.
*/
`timescale 1ns/1ps
`include "fapg_params.svh"
module fapg_guard_test;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, power_down_state, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, acc_addr;
  logic acc_valid, acc_debug, acc_grant, acc_deny, sel, keep, ereq, edone, sinv;
  logic [1:0] acc_op, acc_size;
  logic [2:0] aq[$];
  logic [64:0] bq[$];
  int err_count, comparisons, seed, i;
  fapg_guard fapg_guard_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid), .acc_debug(acc_debug),
    .acc_op(acc_op), .acc_size(acc_size), .acc_addr(acc_addr), .acc_grant(acc_grant),
    .acc_deny(acc_deny), .acc_sram_sel(sel), .acc_boot_keep(keep), .erase_all_req(ereq),
    .erase_all_done(edone), .power_down_state(power_down_state), .sram_invalid(sinv));
  fapg_flash_model fapg_flash_model_inst (.pclk(pclk), .presetn(presetn),
    .erase_all_req(ereq), .erase_all_done(edone));
  // ****************************************
  // Clock, checks and closing
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    err_count++;
    stop_test();
  end
  // ****************************************
  // Monitor: oldest note against each answer
  // ****************************************
  always @(negedge pclk) begin
    logic [64:0] b;
    if (acc_grant === 1'b1 || acc_deny === 1'b1)
      check({29'h0, acc_grant, sel, keep}, {29'h0, aq.pop_front()});
    if (psel && penable && pready === 1'b1) begin
      b = bq.pop_front();
      check({31'h0, pslverr}, {31'h0, b[64]});
      check(prdata & b[63:32], b[31:0]);
    end
  end
  // ****************************************
  // Drivers
  // ****************************************
  // Every register transfer is one aligned 32-bit word.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] m, input logic [31:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    bq.push_back({err, m, e & m});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic acc(input logic dbg, input logic [1:0] op, input logic [1:0] sz,
                     input logic [31:0] a, input logic [2:0] exp);
    @(posedge pclk);
    acc_valid <= 1'b1; acc_debug <= dbg; acc_op <= op; acc_size <= sz; acc_addr <= a;
    aq.push_back(exp);
    @(posedge pclk);
    acc_valid <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0, m, e);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 65;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; acc_valid = 1'b0; acc_debug = 1'b0; acc_op = 2'h0; acc_size = 2'h2;
    acc_addr = 32'h0; power_down_state = 1'b0; clk_en = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FAPG_OFF_AC, 32'hffffffff, `FAPG_AC_RESET);
    apb(1'b0, 12'h01c, 32'h0, 1'b1, 32'h0, 32'h0);
    rd(`FAPG_OFF_REQ, 32'hffffffff, 32'h2);
    acc(1'b0, 2'h1, 2'h2, 32'h00000100, 3'b000);
    acc(1'b0, 2'h2, 2'h2, 32'h00001000, 3'b100);
    acc(1'b1, 2'h0, 2'h2, 32'h00001000, 3'b000);
    acc(1'b1, 2'h0, 2'h2, `FAPG_SRAM_BASE, 3'b010);
    acc(1'b1, 2'h0, 2'h2, `FAPG_OPT_BASE, 3'b100);
    acc(1'b0, 2'h1, 2'h2, `FAPG_SYS_BASE, 3'b000);
    acc(1'b1, 2'h0, 2'h2, `FAPG_SYS_END - 32'h3, 3'b100);
    for (i = 0; i < 3; i++)
      acc(1'b0, 2'h1, i[1:0], `FAPG_SRAM_BASE + ($random(seed) & 32'hbfc), 3'b110);
    acc(1'b0, 2'h0, 2'h2, `FAPG_SRAM_LAST + 32'h1, 3'b000);
    acc(1'b0, 2'h0, 2'h0, `FAPG_SRAM_LAST, 3'b110);
    acc(1'b0, 2'h0, 2'h3, `FAPG_SRAM_BASE, 3'b010);
    rd(`FAPG_OFF_STS, 32'h10, 32'h10);
    wr(`FAPG_OFF_STS, 32'h10);
    rd(`FAPG_OFF_STS, 32'h10, 32'h0);
    wr(`FAPG_OFF_KEY, `FAPG_KEY1); wr(`FAPG_OFF_KEY, `FAPG_KEY2);
    wr(`FAPG_OFF_OPT_KEY, `FAPG_KEY1); wr(`FAPG_OFF_OPT_KEY, `FAPG_KEY2);
    acc(1'b0, 2'h1, 2'h2, `FAPG_OPT_BASE, 3'b100);
    wr(`FAPG_OFF_LVL, 32'hffff5aa5);
    i = 0;
    while (ereq !== 1'b1 && i < 10) begin
      @(negedge pclk);
      i++;
    end
    check({31'h0, ereq}, 32'h1);
    repeat (30) @(posedge pclk);
    rd(`FAPG_OFF_REQ, 32'hffffffff, 32'h1);
    rd(`FAPG_OFF_STS, 32'h20, 32'h20);
    for (i = 0; i < 4; i++)
      acc(1'b1, 2'h0, 2'h2, $random(seed) & 32'h7ffc, 3'b100);
    acc(1'b0, 2'h1, 2'h2, 32'h00000bfc, 3'b000);
    acc(1'b0, 2'h3, 2'h2, 32'h00000000, 3'b101);
    wr(`FAPG_OFF_OPT, 32'h000000f7);
    acc(1'b0, 2'h1, 2'h2, 32'h00000bfc, 3'b100);
    acc(1'b1, 2'h2, 2'h2, 32'h00000000, 3'b100);
    acc(1'b0, 2'h3, 2'h2, 32'h00000000, 3'b100);
    acc(1'b1, 2'h1, 2'h1, `FAPG_SRAM_BASE, 3'b110);
    wr(`FAPG_OFF_LVL, 32'h33cc5aa5);
    rd(`FAPG_OFF_REQ, 32'hffffffff, 32'h4);
    wr(`FAPG_OFF_STS, 32'h10);
    wr(`FAPG_OFF_LVL, 32'hffff5aa5);
    rd(`FAPG_OFF_REQ, 32'hffffffff, 32'h4);
    rd(`FAPG_OFF_STS, 32'h10, 32'h10);
    acc(1'b0, 2'h1, 2'h2, `FAPG_OPT_BASE, 3'b000);
    acc(1'b0, 2'h0, 2'h2, `FAPG_OPT_END - 32'h3, 3'b100);
    acc(1'b1, 2'h0, 2'h2, `FAPG_OPT_BASE, 3'b000);
    acc(1'b0, 2'h1, 2'h2, 32'h00000000, 3'b000);
    acc(1'b0, 2'h1, 2'h2, 32'h00004000, 3'b100);
    // A frozen block must not answer a request that would otherwise be granted.
    @(posedge pclk);
    clk_en <= 1'b0; acc_valid <= 1'b1; acc_op <= 2'h0; acc_addr <= 32'h0;
    repeat (2) @(negedge pclk);
    check({31'h0, acc_grant}, 32'h0);
    @(posedge pclk);
    acc_valid <= 1'b0; clk_en <= 1'b1;
    @(posedge pclk);
    power_down_state <= 1'b1;
    @(posedge pclk);
    power_down_state <= 1'b0;
    repeat (2) @(negedge pclk);
    check({31'h0, sinv}, 32'h1);
    acc(1'b0, 2'h1, 2'h2, `FAPG_SRAM_BASE, 3'b110);
    repeat (2) @(negedge pclk);
    check({31'h0, sinv}, 32'h0);
    check(aq.size() + bq.size(), 32'h0);
    stop_test();
  end
endmodule
